// ==== irq_pkg.sv ====
`default_nettype none
package irq_pkg;

  // ----------------------------------------------------------------
  // sources and bit positions
  // ----------------------------------------------------------------
  localparam int unsigned NUM_SRC   = 9;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned BIT_TICK  = 0;
  localparam int unsigned BIT_RX    = 1;
  localparam int unsigned BIT_SLEEP = 2;
  localparam int unsigned BIT_EVENT = 3;
  localparam int unsigned BIT_CIPH  = 4;
  localparam int unsigned BIT_FAULT = 5;
  localparam int unsigned BIT_GROSS = 6;
  localparam int unsigned BIT_FINE  = 7;
  localparam int unsigned BIT_RADIO = 8;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_MASK_CTRL  = 32'h4000000c;
  localparam logic [31:0] ADDR_MASKED_ST  = 32'h40000010;
  localparam logic [31:0] ADDR_RAW_ST     = 32'h40000014;
  localparam logic [31:0] ADDR_ACK        = 32'h40000018;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [8:0]  MASK_RESET      = 9'h01f;
  localparam logic [8:0]  FLAG_RESET      = 9'h000;
  localparam logic [31:0] RDATA_RESET     = 32'h00000000;
  // flags stay high until acknowledged, never pulsed
  localparam logic        IRQ_LEVEL_STYLE = 1'h1;

  // ----------------------------------------------------------------
  // register select, one-hot
  // ----------------------------------------------------------------
  typedef logic [3:0] reg_sel_t;
  localparam int unsigned SEL_MASK   = 0;
  localparam int unsigned SEL_MASKED = 1;
  localparam int unsigned SEL_RAW    = 2;
  localparam int unsigned SEL_ACK    = 3;

  function automatic reg_sel_t addr_to_sel(input logic [31:0] addr);
    reg_sel_t sel;
    sel             = 4'h0;
    sel[SEL_MASK]   = (addr == ADDR_MASK_CTRL);
    sel[SEL_MASKED] = (addr == ADDR_MASKED_ST);
    sel[SEL_RAW]    = (addr == ADDR_RAW_ST);
    sel[SEL_ACK]    = (addr == ADDR_ACK);
    return sel;
  endfunction

endpackage
`default_nettype wire

// ==== irq_flag_cell.sv ====
`timescale 1ns/1ns
`default_nettype none
module irq_flag_cell (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic src_event,
  input  wire logic clear,
  input  wire logic enable,
  output logic      raw,
  output logic      masked
);

  logic raw_q;
  logic raw_d;

  // an event in the clearing cycle keeps the flag set
  always_comb
  begin
    raw_d = src_event | (raw_q & ~clear);
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      raw_q <= 1'h0;
    else
      raw_q <= raw_d;
  end

  assign raw    = raw_q;
  assign masked = raw_q & enable;

endmodule
`default_nettype wire

// ==== apb_reg_decode.sv ====
`timescale 1ns/1ns
`default_nettype none
module apb_reg_decode (
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic                pready,
  input  wire logic [31:0]         paddr,
  output irq_pkg::reg_sel_t        sel,
  output logic                     setup_read,
  output logic                     write_take,
  output logic                     unmapped
);

  assign sel        = irq_pkg::addr_to_sel(paddr);
  assign setup_read = psel & ~penable & ~pwrite;
  assign write_take = psel & penable & pwrite & pready;
  assign unmapped   = (sel == 4'h0);

endmodule
`default_nettype wire

// ==== radio_core_irq_status_ack.sv ====
// The APB slave port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module radio_core_irq_status_ack (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // source events, one bit per source, same clock
  input  wire logic [8:0]  src_event,
  // status towards the core
  output logic [8:0]       raw_status,
  output logic [8:0]       masked_status,
  output logic             irq_level_style,
  output logic             core_irq
);

  // ----------------------------------------------------------------
  // apb phase tracking
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_SETUP  = 2'b01,
    PH_ACCESS = 2'b11
  } apb_phase_e;

  apb_phase_e        phase_q;
  apb_phase_e        phase_d;
  irq_pkg::reg_sel_t sel;
  logic              setup_read;
  logic              write_take;
  logic              unmapped;

  apb_reg_decode u_decode (
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .pready     (pready),
    .paddr      (paddr),
    .sel        (sel),
    .setup_read (setup_read),
    .write_take (write_take),
    .unmapped   (unmapped)
  );

  always_comb
  begin
    case (phase_q)
      PH_IDLE:
      begin
        phase_d = psel ? PH_SETUP : PH_IDLE;
      end
      PH_SETUP:
      begin
        phase_d = (psel && penable) ? PH_ACCESS : phase_q;
      end
      PH_ACCESS:
      begin
        phase_d = psel ? PH_SETUP : PH_IDLE;
      end
      default:
      begin
        phase_d = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      phase_q <= PH_IDLE;
    else
      phase_q <= phase_d;
  end

  // one access cycle: the answer is already registered in setup
  assign pready = psel & penable & (phase_q == PH_SETUP);

  // ----------------------------------------------------------------
  // mask register
  // ----------------------------------------------------------------
  logic [8:0] mask_q;
  logic [8:0] mask_d;

  always_comb
  begin
    mask_d = mask_q;
    if (write_take && sel[irq_pkg::SEL_MASK])
      mask_d = pwdata[8:0];
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      mask_q <= irq_pkg::MASK_RESET;
    else
      mask_q <= mask_d;
  end

  // ----------------------------------------------------------------
  // acknowledge strobes
  // ----------------------------------------------------------------
  logic [8:0] ack_bits;

  // write-only: a zero bit leaves its flag alone
  always_comb
  begin
    ack_bits = 9'h000;
    if (write_take && sel[irq_pkg::SEL_ACK])
      ack_bits = pwdata[8:0];
  end

  // ----------------------------------------------------------------
  // pending flags
  // ----------------------------------------------------------------
  logic [8:0] raw_w;
  logic [8:0] masked_w;

  // one cell per source; ack bit i clears source i only,
  // so end-of-event ack clears the event flags, not sleep
  for (genvar i = 0; i < irq_pkg::NUM_SRC; i++)
  begin : g_src
    irq_flag_cell u_flag (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .src_event (src_event[i]),
      .clear     (ack_bits[i]),
      .enable    (mask_q[i]),
      .raw       (raw_w[i]),
      .masked    (masked_w[i])
    );
  end

  assign raw_status      = raw_w;
  assign masked_status   = masked_w;
  assign core_irq        = |masked_w;
  assign irq_level_style = irq_pkg::IRQ_LEVEL_STYLE;

  // ----------------------------------------------------------------
  // read data and error
  // ----------------------------------------------------------------
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        err_q;
  logic        err_d;

  // captured in setup so prdata comes from flops
  always_comb
  begin
    rdata_d = rdata_q;
    err_d   = err_q;
    if (psel && !penable)
    begin
      err_d   = unmapped;
      rdata_d = irq_pkg::RDATA_RESET;
      if (setup_read)
      begin
        case (1'b1)
          sel[irq_pkg::SEL_MASK]:   rdata_d[8:0] = mask_q;
          sel[irq_pkg::SEL_MASKED]: rdata_d[8:0] = masked_w;
          sel[irq_pkg::SEL_RAW]:    rdata_d[8:0] = raw_w;
          default:                  rdata_d      = irq_pkg::RDATA_RESET;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata_q <= irq_pkg::RDATA_RESET;
      err_q   <= 1'h0;
    end
    else
    begin
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  assign prdata  = rdata_q;
  assign pslverr = pready & err_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic rst_done_q;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_done_q <= 1'h0;
    else
      rst_done_q <= 1'h1;
  end

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_read_raw;
    s_setup ##0 (!pwrite && sel[irq_pkg::SEL_RAW]);
  endsequence

  sequence s_read_ack;
    s_setup ##0 (!pwrite && sel[irq_pkg::SEL_ACK]);
  endsequence

  sequence s_access;
    psel && penable;
  endsequence

  sequence s_read_mask;
    s_setup ##0 (!pwrite && sel[irq_pkg::SEL_MASK]);
  endsequence

  sequence s_read_masked;
    s_setup ##0 (!pwrite && sel[irq_pkg::SEL_MASKED]);
  endsequence

  sequence s_bad_addr;
    s_setup ##0 unmapped;
  endsequence

  a_reset_state: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    !rst_done_q |-> (mask_q == irq_pkg::MASK_RESET && raw_w == 9'h000 && !core_irq))
    else $error("state after reset wrong");

  a_event_sets: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (|src_event) |=> ((raw_w & $past(src_event)) == $past(src_event)))
    else $error("event did not set its flag");

  a_ack_clears: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (|ack_bits) |=> ((raw_w & $past(ack_bits & ~src_event)) == 9'h000))
    else $error("acknowledge left a flag set");

  a_zero_no_effect: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (|raw_w) |=> ((raw_w & $past(raw_w & ~ack_bits)) == $past(raw_w & ~ack_bits)))
    else $error("flag dropped without acknowledge");

  a_masked_gate: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (write_take && sel[irq_pkg::SEL_MASK]) |=>
      (mask_q == $past(pwdata[8:0])) ##0 (masked_status == (raw_status & mask_q)))
    else $error("mask write or gating wrong");

  a_irq_level: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (core_irq && !write_take) |=> core_irq)
    else $error("interrupt dropped without a write");

  a_read_raw: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_read_raw |=> (pready && prdata == {23'h000000, $past(raw_w)}))
    else $error("raw status read wrong");

  a_ack_reads_zero: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_read_ack |=> (prdata == irq_pkg::RDATA_RESET))
    else $error("acknowledge register not write-only");

  a_reserved_zero: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    pready |-> (prdata[31:9] == 23'h000000))
    else $error("reserved read bits not zero");

  a_zero_wait: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_setup ##1 s_access |-> pready)
    else $error("access phase not answered at once");

  a_pready_pulse: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    pready |=> !pready)
    else $error("ready held past one cycle");

  a_read_mask: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_read_mask |=> (prdata == {23'h000000, $past(mask_q)}))
    else $error("mask read wrong");

  a_read_masked: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_read_masked |=> (prdata == {23'h000000, $past(masked_w)}))
    else $error("masked status read wrong");

  a_bad_addr_err: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_bad_addr ##1 s_access |-> pslverr)
    else $error("unmapped access without error");

  a_status_ro: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (write_take && (sel[irq_pkg::SEL_MASKED] || sel[irq_pkg::SEL_RAW])) |=>
      (mask_q == $past(mask_q) && (raw_w & $past(raw_w)) == $past(raw_w)))
    else $error("status write changed state");

  a_set_needs_event: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    1'b1 |=> ((raw_w & ~$past(raw_w) & ~$past(src_event)) == 9'h000))
    else $error("flag set without its event");

  a_set_wins: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (|(ack_bits & src_event)) |=>
      ((raw_w & $past(ack_bits & src_event)) == $past(ack_bits & src_event)))
    else $error("clear beat a coinciding event");

endmodule
`default_nettype wire

// ==== radio_core_irq_status_ack_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module radio_core_irq_status_ack_test;
  logic        sys_clk   = 1'b0;
  logic        reset_n   = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [31:0] paddr     = 32'h0;
  logic [31:0] pwdata    = 32'h0;
  logic [8:0]  src_event = 9'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [8:0]  raw_status;
  logic [8:0]  masked_status;
  logic        irq_level_style;
  logic        core_irq;
  int          num_errors = 0;
  int          checks     = 0;
  int          cycles     = 0;
  logic [31:0] rdat;
  logic        rerr;
  logic [31:0] b;
  localparam logic [31:0] A_MASK = irq_pkg::ADDR_MASK_CTRL;
  localparam logic [31:0] A_MST  = irq_pkg::ADDR_MASKED_ST;
  localparam logic [31:0] A_RAW  = irq_pkg::ADDR_RAW_ST;
  localparam logic [31:0] A_ACK  = irq_pkg::ADDR_ACK;

  radio_core_irq_status_ack dut (
    .sys_clk         (sys_clk),
    .reset_n         (reset_n),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .src_event       (src_event),
    .raw_status      (raw_status),
    .masked_status   (masked_status),
    .irq_level_style (irq_level_style),
    .core_irq        (core_irq)
  );

  always #25 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      $display("CHECK FAILED run_length expected finish seen hang");
      end_sim();
    end
  end

  // ------------------------------------------------------------
  // bus tasks and compare
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // the answer is taken at the rising edge that sees pready high; all state
  // moves by nonblocking assignment, so the pre-edge values are still visible
  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk("access_cycles", 32'h1, n);
  endtask

  task automatic rd(input logic [31:0] addr, input logic [31:0] exp, input string name);
    apb(1'b0, addr, 32'h0);
    chk(name, exp, rdat);
  endtask

  task automatic pulse(input logic [8:0] bits);
    @(posedge sys_clk);
    src_event <= bits;
    @(posedge sys_clk);
    src_event <= 9'h0;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    chk("core_irq", 32'h0, {31'h0, core_irq});
    chk("level_style", 32'h1, {31'h0, irq_level_style});
    rd(A_MASK, 32'h0000001f, "mask_reset");
    rd(A_MST, 32'h0, "masked_reset");
    rd(A_RAW, 32'h0, "raw_reset");
    rd(A_ACK, 32'h0, "ack_read");
    $display("test reset done");

    apb(1'b1, A_MASK, 32'h1ff);
    for (int i = 0; i < 9; i++)
    begin
      b = 32'h1 << i;
      pulse(b[8:0]);
      repeat (3) @(posedge sys_clk);
      rd(A_RAW, b, "raw_set");
      rd(A_MST, b, "masked_set");
      chk("core_irq", 32'h1, {31'h0, core_irq});
      chk("raw_port", b, {23'h0, raw_status});
      chk("masked_port", b, {23'h0, masked_status});
      apb(1'b1, A_ACK, ~b & 32'h1ff);
      apb(1'b1, A_ACK, 32'h0);
      rd(A_RAW, b, "raw_kept");
      apb(1'b1, A_ACK, b);
      rd(A_RAW, 32'h0, "raw_cleared");
      rd(A_MST, 32'h0, "masked_cleared");
      chk("core_irq", 32'h0, {31'h0, core_irq});
    end
    $display("test per source done");

    apb(1'b1, A_MASK, 32'h0);
    pulse(9'h1ff);
    rd(A_RAW, 32'h1ff, "raw_all");
    rd(A_MST, 32'h0, "masked_none");
    chk("core_irq", 32'h0, {31'h0, core_irq});
    apb(1'b1, A_MASK, 32'hfffffeaa);
    rd(A_MASK, 32'h0aa, "mask_rw");
    rd(A_MST, 32'h0aa, "masked_part");
    chk("core_irq", 32'h1, {31'h0, core_irq});
    apb(1'b1, A_RAW, 32'h0);
    rd(A_RAW, 32'h1ff, "raw_ro");
    rd(A_ACK, 32'h0, "ack_wo");
    $display("test masking done");

    rd(32'h4000001c, 32'h0, "unmapped_data");
    chk("slverr_unmapped", 32'h1, {31'h0, rerr});
    rd(A_MASK, 32'h0aa, "mask_again");
    chk("slverr_mapped", 32'h0, {31'h0, rerr});
    $display("test unmapped done");

    // event lands on the very edge that takes the acknowledge
    apb(1'b1, A_ACK, 32'h1ff);
    pulse(9'h020);
    fork
      apb(1'b1, A_ACK, 32'h20);
      begin
        @(posedge sys_clk);
        @(posedge sys_clk);
        src_event <= 9'h020;
        @(posedge sys_clk);
        src_event <= 9'h0;
      end
    join
    rd(A_RAW, 32'h20, "raw_set_wins");
    $display("test set wins done");

    @(posedge sys_clk);
    reset_n <= 1'b0;
    @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    chk("raw_port", 32'h0, {23'h0, raw_status});
    chk("masked_port", 32'h0, {23'h0, masked_status});
    rd(A_MASK, 32'h0000001f, "mask_rereset");
    $display("test second reset done");
    end_sim();
  end
endmodule
`default_nettype wire
